// file: design/adc_ctrl_pkg.sv
// constants, register map and codes for the converter control block
package adc_ctrl_pkg;
  // clock and wake-up timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_SLOW_NS = 15000;
  localparam int WAKE_FAST_NS = 100;
  localparam int CLK_STOP_NS = 1000;
  localparam int WAKE_SLOW_CNT = (WAKE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_FAST_CNT = (WAKE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_STOP_CNT = (CLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W = 9;
  localparam logic [WAIT_W-1:0] SLOW_LOAD = WAIT_W'(WAKE_SLOW_CNT);
  localparam logic [WAIT_W-1:0] FAST_LOAD = WAIT_W'(WAKE_FAST_CNT);
  localparam logic [WAIT_W-1:0] STOP_LIMIT = WAIT_W'(CLK_STOP_CNT);
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 9'h000;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 9'h001;

  // data path
  localparam int SAMPLE_W = 14;
  localparam int LATENCY = 14;
  localparam int PAIRS = 11;
  localparam int CHANNELS = 2;

  // register map
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_POWER = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // config fields
  localparam int CFG_REF_EXT = 0;
  localparam int CFG_COARSE = 1;
  localparam int CFG_FINE_LSB = 4;
  localparam int FINE_W = 4;
  localparam int CFG_DATA_DRV = 8;
  localparam int CFG_CLK_DRV = 9;
  localparam int CFG_DDR = 10;
  localparam int CFG_PIN_CTRL = 11;
  localparam logic [FINE_W-1:0] FINE_MAX = 4'hC;
  localparam logic [FINE_W-1:0] FINE_RESET = 4'h0;

  // status fields
  localparam int ST_CODE_LSB = 0;
  localparam int ST_DDR = 3;
  localparam int ST_LOW_PWR = 4;
  localparam int ST_VALID_A = 5;
  localparam int ST_VALID_B = 6;
  localparam int ST_REF_ON = 7;

  typedef enum logic [2:0] {
    PWR_NORMAL = 3'h0,
    PWR_BUF_A_OFF = 3'h1,
    PWR_BUF_B_OFF = 3'h2,
    PWR_BUF_AB_OFF = 3'h3,
    PWR_GLOBAL_DOWN = 3'h4,
    PWR_STANDBY_A = 3'h5,
    PWR_STANDBY_B = 3'h6,
    PWR_MUX = 3'h7
  } power_code_t;
endpackage

// file: design/adc_power_mode_output_port.sv
// power mode, gain/reference control and output port of the dual converter
`timescale 1ns/1ns
module adc_power_mode_output_port (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic POWER_CODE_PIN_HI,
  input wire logic POWER_CODE_PIN_MID,
  input wire logic POWER_CODE_PIN_LO,
  input wire logic INTERFACE_SELECT_PIN,
  input wire logic SAMPLE_CLOCK,
  input wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] CONV_A_SAMPLE,
  input wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] CONV_B_SAMPLE,
  output logic REF_EXTERNAL,
  output logic REF_ON,
  output logic COARSE_GAIN_ON,
  output logic [adc_ctrl_pkg::FINE_W-1:0] FINE_GAIN_STEPS,
  output logic CONV_A_ON,
  output logic CONV_B_ON,
  output logic LOW_POWER,
  output logic DATA_VALID_A,
  output logic DATA_VALID_B,
  output logic DATA_DRIVE_LEVEL,
  output logic CLOCK_DRIVE_LEVEL,
  output logic [adc_ctrl_pkg::SAMPLE_W-1:0] CHAN_A_BUS,
  output logic [adc_ctrl_pkg::SAMPLE_W-1:0] CHAN_B_BUS,
  output logic CHAN_A_OE,
  output logic CHAN_B_OE,
  output logic SINGLE_ENDED_OUT_CLOCK,
  output logic [adc_ctrl_pkg::PAIRS-1:0] DDR_A_PAIRS,
  output logic [adc_ctrl_pkg::PAIRS-1:0] DDR_B_PAIRS,
  output logic DDR_A_OE,
  output logic DDR_B_OE,
  output logic DDR_OUT_CLOCK_POS,
  output logic DDR_OUT_CLOCK_NEG
);
  localparam int SW = adc_ctrl_pkg::SAMPLE_W;
  localparam int WW = adc_ctrl_pkg::WAIT_W;

  // configuration and power registers
  logic ref_ext_r, coarse_r, data_drv_r, clk_drv_r, ddr_cfg_r, pin_ctrl_r;
  logic [adc_ctrl_pkg::FINE_W-1:0] fine_r, fine_nxt;
  logic [2:0] power_reg_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, rdata_nxt;
  logic access, access_done, mapped;

  // pin synchronisers
  logic [2:0] code_meta_r, code_sync_r;
  logic sel_meta_r, sel_sync_r;
  logic sclk_meta_r, sclk_sync_r, sclk_d_r;
  logic [2*SW-1:0] smp_meta_r, smp_sync_r;
  logic rise, fall;

  // effective mode
  adc_ctrl_pkg::power_code_t eff_code_r;
  logic ddr_eff_r, mux_on;
  logic [1:0] buf_off, conv_off;
  logic global_off;
  logic [WW-1:0] buf_wait_r [adc_ctrl_pkg::CHANNELS];
  logic [WW-1:0] conv_wait_r [adc_ctrl_pkg::CHANNELS];
  logic [1:0] chan_oe_r, ddr_oe_r, valid_r, conv_on_r;
  logic [WW-1:0] stop_cnt_r;
  logic low_power_r, ref_on_r;

  // data path
  logic [2*SW-1:0] delayed;
  logic [SW-1:0] out_a, out_b;
  logic [adc_ctrl_pkg::PAIRS-1:0] odd_a, odd_b, even_a, even_b;
  logic [SW-1:0] a_bus_r, b_bus_r;
  logic [adc_ctrl_pkg::PAIRS-1:0] ddr_a_r, ddr_b_r, even_a_r, even_b_r;
  logic se_clk_r, ddr_clk_r, ddr_clkn_r;

  // apb slave, one wait state
  assign access = PSEL && PENABLE;
  assign access_done = access && pready_r;
  assign mapped = (PADDR == adc_ctrl_pkg::ADDR_CONFIG) || (PADDR == adc_ctrl_pkg::ADDR_POWER)
    || (PADDR == adc_ctrl_pkg::ADDR_STATUS);

  always_comb
  begin
    rdata_nxt = '0;
    unique case (PADDR)
      adc_ctrl_pkg::ADDR_CONFIG:
      begin
        rdata_nxt[adc_ctrl_pkg::CFG_REF_EXT] = ref_ext_r;
        rdata_nxt[adc_ctrl_pkg::CFG_COARSE] = coarse_r;
        rdata_nxt[adc_ctrl_pkg::CFG_FINE_LSB +: adc_ctrl_pkg::FINE_W] = fine_r;
        rdata_nxt[adc_ctrl_pkg::CFG_DATA_DRV] = data_drv_r;
        rdata_nxt[adc_ctrl_pkg::CFG_CLK_DRV] = clk_drv_r;
        rdata_nxt[adc_ctrl_pkg::CFG_DDR] = ddr_cfg_r;
        rdata_nxt[adc_ctrl_pkg::CFG_PIN_CTRL] = pin_ctrl_r;
      end
      adc_ctrl_pkg::ADDR_POWER:
        rdata_nxt[2:0] = power_reg_r;
      adc_ctrl_pkg::ADDR_STATUS:
      begin
        rdata_nxt[adc_ctrl_pkg::ST_CODE_LSB +: 3] = eff_code_r;
        rdata_nxt[adc_ctrl_pkg::ST_DDR] = ddr_eff_r;
        rdata_nxt[adc_ctrl_pkg::ST_LOW_PWR] = low_power_r;
        rdata_nxt[adc_ctrl_pkg::ST_VALID_A] = valid_r[0];
        rdata_nxt[adc_ctrl_pkg::ST_VALID_B] = valid_r[1];
        rdata_nxt[adc_ctrl_pkg::ST_REF_ON] = ref_on_r;
      end
      default:
        rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= access && !pready_r;
      pslverr_r <= access && !pready_r && !mapped;
      prdata_r <= (access && !pready_r && !PWRITE) ? rdata_nxt : 32'h00000000;
    end
  end

  // fine gain clamps at six dB
  always_comb
  begin
    fine_nxt = PWDATA[adc_ctrl_pkg::CFG_FINE_LSB +: adc_ctrl_pkg::FINE_W];
    if (fine_nxt > adc_ctrl_pkg::FINE_MAX)
      fine_nxt = adc_ctrl_pkg::FINE_MAX;
  end

  // configuration held apart from power code writes
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ref_ext_r <= 1'b0;
      coarse_r <= 1'b0;
      fine_r <= adc_ctrl_pkg::FINE_RESET;
      data_drv_r <= 1'b0;
      clk_drv_r <= 1'b0;
      ddr_cfg_r <= 1'b0;
      pin_ctrl_r <= 1'b0;
    end
    else if (access_done && PWRITE && PADDR == adc_ctrl_pkg::ADDR_CONFIG)
    begin
      ref_ext_r <= PWDATA[adc_ctrl_pkg::CFG_REF_EXT];
      coarse_r <= PWDATA[adc_ctrl_pkg::CFG_COARSE];
      fine_r <= fine_nxt;
      data_drv_r <= PWDATA[adc_ctrl_pkg::CFG_DATA_DRV];
      clk_drv_r <= PWDATA[adc_ctrl_pkg::CFG_CLK_DRV];
      ddr_cfg_r <= PWDATA[adc_ctrl_pkg::CFG_DDR];
      pin_ctrl_r <= PWDATA[adc_ctrl_pkg::CFG_PIN_CTRL];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      power_reg_r <= adc_ctrl_pkg::PWR_NORMAL;
    else if (access_done && PWRITE && PADDR == adc_ctrl_pkg::ADDR_POWER)
      power_reg_r <= PWDATA[2:0];
  end

  // two-flop synchronisers for every pin
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      code_meta_r <= 3'h0;
      code_sync_r <= 3'h0;
      sel_meta_r <= 1'b0;
      sel_sync_r <= 1'b0;
      sclk_meta_r <= 1'b0;
      sclk_sync_r <= 1'b0;
      sclk_d_r <= 1'b0;
      smp_meta_r <= '0;
      smp_sync_r <= '0;
    end
    else
    begin
      code_meta_r <= {POWER_CODE_PIN_HI, POWER_CODE_PIN_MID, POWER_CODE_PIN_LO};
      code_sync_r <= code_meta_r;
      sel_meta_r <= INTERFACE_SELECT_PIN;
      sel_sync_r <= sel_meta_r;
      sclk_meta_r <= SAMPLE_CLOCK;
      sclk_sync_r <= sclk_meta_r;
      sclk_d_r <= sclk_sync_r;
      smp_meta_r <= {CONV_B_SAMPLE, CONV_A_SAMPLE};
      smp_sync_r <= smp_meta_r;
    end
  end

  assign rise = sclk_sync_r && !sclk_d_r;
  assign fall = !sclk_sync_r && sclk_d_r;

  // effective power code and interface
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      eff_code_r <= adc_ctrl_pkg::PWR_NORMAL;
      ddr_eff_r <= 1'b0;
    end
    else
    begin
      eff_code_r <= adc_ctrl_pkg::power_code_t'(pin_ctrl_r ? code_sync_r : power_reg_r);
      ddr_eff_r <= pin_ctrl_r ? sel_sync_r : ddr_cfg_r;
    end
  end

  // multiplexing exists only on the single-ended port
  assign mux_on = (eff_code_r == adc_ctrl_pkg::PWR_MUX) && !ddr_eff_r;
  assign global_off = eff_code_r == adc_ctrl_pkg::PWR_GLOBAL_DOWN;
  assign buf_off[0] = global_off || mux_on || (eff_code_r == adc_ctrl_pkg::PWR_BUF_A_OFF)
    || (eff_code_r == adc_ctrl_pkg::PWR_BUF_AB_OFF);
  assign buf_off[1] = global_off || (eff_code_r == adc_ctrl_pkg::PWR_BUF_B_OFF)
    || (eff_code_r == adc_ctrl_pkg::PWR_BUF_AB_OFF);
  assign conv_off[0] = global_off || (eff_code_r == adc_ctrl_pkg::PWR_STANDBY_A);
  assign conv_off[1] = global_off || (eff_code_r == adc_ctrl_pkg::PWR_STANDBY_B);

  // per-channel wake timers
  genvar c;
  generate
    for (c = 0; c < adc_ctrl_pkg::CHANNELS; c++)
    begin : g_chan
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          buf_wait_r[c] <= adc_ctrl_pkg::WAIT_ZERO;
          conv_wait_r[c] <= adc_ctrl_pkg::WAIT_ZERO;
          chan_oe_r[c] <= 1'b0;
          ddr_oe_r[c] <= 1'b0;
          valid_r[c] <= 1'b0;
          conv_on_r[c] <= 1'b1;
        end
        else
        begin
          if (buf_off[c])
            buf_wait_r[c] <= adc_ctrl_pkg::FAST_LOAD;
          else if (buf_wait_r[c] != adc_ctrl_pkg::WAIT_ZERO)
            buf_wait_r[c] <= buf_wait_r[c] - adc_ctrl_pkg::WAIT_ONE;
          if (conv_off[c])
            conv_wait_r[c] <= global_off ? adc_ctrl_pkg::SLOW_LOAD : adc_ctrl_pkg::FAST_LOAD;
          else if (conv_wait_r[c] != adc_ctrl_pkg::WAIT_ZERO)
            conv_wait_r[c] <= conv_wait_r[c] - adc_ctrl_pkg::WAIT_ONE;
          chan_oe_r[c] <= !buf_off[c] && buf_wait_r[c] == adc_ctrl_pkg::WAIT_ZERO && !ddr_eff_r;
          ddr_oe_r[c] <= !buf_off[c] && buf_wait_r[c] == adc_ctrl_pkg::WAIT_ZERO && ddr_eff_r;
          // watchdog count, not its flag, so valid drops with low power
          valid_r[c] <= !conv_off[c] && conv_wait_r[c] == adc_ctrl_pkg::WAIT_ZERO
            && stop_cnt_r < adc_ctrl_pkg::STOP_LIMIT;
          conv_on_r[c] <= !conv_off[c];
        end
      end
    end
  endgenerate

  // sampling clock watchdog
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      stop_cnt_r <= adc_ctrl_pkg::WAIT_ZERO;
      low_power_r <= 1'b0;
      ref_on_r <= 1'b1;
    end
    else
    begin
      if (rise)
        stop_cnt_r <= adc_ctrl_pkg::WAIT_ZERO;
      else if (stop_cnt_r < adc_ctrl_pkg::STOP_LIMIT)
        stop_cnt_r <= stop_cnt_r + adc_ctrl_pkg::WAIT_ONE;
      low_power_r <= stop_cnt_r >= adc_ctrl_pkg::STOP_LIMIT;
      ref_on_r <= !global_off;
    end
  end

  sample_delay_line #(
    .WIDTH(2 * SW),
    .DEPTH(adc_ctrl_pkg::LATENCY)
  ) u_delay (
    .clk(CLK),
    .rst(RST),
    .shift(rise),
    .din(smp_sync_r),
    .dout(delayed)
  );

  assign out_a = delayed[SW-1:0];
  assign out_b = delayed[2*SW-1:SW];

  // split words into odd and even bit lanes, unused pairs low
  genvar p;
  generate
    for (p = 0; p < adc_ctrl_pkg::PAIRS; p++)
    begin : g_pair
      if (2 * p + 1 < SW)
      begin : g_full
        assign odd_a[p] = out_a[2*p+1];
        assign odd_b[p] = out_b[2*p+1];
      end
      else
      begin : g_odd_idle
        assign odd_a[p] = 1'b0;
        assign odd_b[p] = 1'b0;
      end
      if (2 * p < SW)
      begin : g_even
        assign even_a[p] = out_a[2*p];
        assign even_b[p] = out_b[2*p];
      end
      else
      begin : g_even_idle
        assign even_a[p] = 1'b0;
        assign even_b[p] = 1'b0;
      end
    end
  endgenerate

  // output launch: cmos data on fall so the out clock rise sits mid-word, except mux mode, where out_b goes onto the B bus on rise
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      a_bus_r <= '0;
      b_bus_r <= '0;
      ddr_a_r <= '0;
      ddr_b_r <= '0;
      even_a_r <= '0;
      even_b_r <= '0;
      se_clk_r <= 1'b0;
      ddr_clk_r <= 1'b0;
      ddr_clkn_r <= 1'b1;
    end
    else if (rise)
    begin
      se_clk_r <= !ddr_eff_r;
      ddr_clk_r <= ddr_eff_r;
      ddr_clkn_r <= !ddr_eff_r;
      if (ddr_eff_r)
      begin
        ddr_a_r <= odd_a;
        ddr_b_r <= odd_b;
        // even half held, the delay line moves on at this same rise
        even_a_r <= even_a;
        even_b_r <= even_b;
      end
      else if (mux_on)
        b_bus_r <= out_b;
    end
    else if (fall)
    begin
      se_clk_r <= 1'b0;
      ddr_clk_r <= 1'b0;
      ddr_clkn_r <= 1'b1;
      if (ddr_eff_r)
      begin
        ddr_a_r <= even_a_r;
        ddr_b_r <= even_b_r;
      end
      else
      begin
        a_bus_r <= out_a;
        b_bus_r <= mux_on ? out_a : out_b;
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign REF_EXTERNAL = ref_ext_r;
  assign REF_ON = ref_on_r;
  assign COARSE_GAIN_ON = coarse_r;
  assign FINE_GAIN_STEPS = fine_r;
  assign CONV_A_ON = conv_on_r[0];
  assign CONV_B_ON = conv_on_r[1];
  assign LOW_POWER = low_power_r;
  assign DATA_VALID_A = valid_r[0];
  assign DATA_VALID_B = valid_r[1];
  assign DATA_DRIVE_LEVEL = data_drv_r;
  assign CLOCK_DRIVE_LEVEL = clk_drv_r;
  assign CHAN_A_BUS = a_bus_r;
  assign CHAN_B_BUS = b_bus_r;
  assign CHAN_A_OE = chan_oe_r[0];
  assign CHAN_B_OE = chan_oe_r[1];
  assign SINGLE_ENDED_OUT_CLOCK = se_clk_r;
  assign DDR_A_PAIRS = ddr_a_r;
  assign DDR_B_PAIRS = ddr_b_r;
  assign DDR_A_OE = ddr_oe_r[0];
  assign DDR_B_OE = ddr_oe_r[1];
  assign DDR_OUT_CLOCK_POS = ddr_clk_r;
  assign DDR_OUT_CLOCK_NEG = ddr_clkn_r;

  AST_GAIN_RESET: assert property (@(posedge CLK) $fell(RST) |-> !COARSE_GAIN_ON && FINE_GAIN_STEPS == 4'h0) else $error("gain not zero after reset");
  AST_FINE_RANGE: assert property (@(posedge CLK) disable iff (RST) FINE_GAIN_STEPS <= 4'hC) else $error("fine gain above six dB");
  AST_BUF_A_OFF: assert property (@(posedge CLK) disable iff (RST) eff_code_r == adc_ctrl_pkg::PWR_BUF_A_OFF |=> !CHAN_A_OE && !DDR_A_OE) else $error("channel A still driving");
  AST_GLOBAL_DOWN: assert property (@(posedge CLK) disable iff (RST) global_off |=> !REF_ON && !CONV_A_ON && !CONV_B_ON && !CHAN_B_OE) else $error("global down incomplete");
  AST_MUX_A_FLOAT: assert property (@(posedge CLK) disable iff (RST) mux_on |=> !CHAN_A_OE) else $error("A bus driven in mux mode");
  AST_SLOW_WAKE: assert property (@(posedge CLK) disable iff (RST) $past(global_off) && !global_off |-> !DATA_VALID_A [*8]) else $error("wake from global down too fast");
  AST_FAST_REENABLE: assert property (@(posedge CLK) disable iff (RST) (eff_code_r == adc_ctrl_pkg::PWR_NORMAL && !ddr_eff_r) [*5] |=> CHAN_A_OE) else $error("buffer not re-enabled in time");
  AST_CLOCK_STOP: assert property (@(posedge CLK) disable iff (RST)
    stop_cnt_r >= adc_ctrl_pkg::STOP_LIMIT |=> LOW_POWER && !DATA_VALID_B)
    else $error("no low power on clock stop");
  AST_DDR_ODD_RISE: assert property (@(posedge CLK) disable iff (RST) rise && ddr_eff_r |=> DDR_A_PAIRS[0] == $past(out_a[1]) && DDR_OUT_CLOCK_POS) else $error("odd bit not on rise");
  AST_CMOS_WORD: assert property (@(posedge CLK) disable iff (RST) fall && !ddr_eff_r && !mux_on |=> CHAN_A_BUS == $past(out_a) && CHAN_B_BUS == $past(out_b)) else $error("cmos word not launched");
endmodule

// file: design/sample_delay_line.sv
// pipeline delay of the converted sample pair, one stage per rising sampling clock edge
`timescale 1ns/1ns
module sample_delay_line #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic shift,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_r [DEPTH];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_stage
      always_ff @(posedge clk)
      begin
        if (rst)
          stage_r[i] <= '0;
        else if (shift)
          stage_r[i] <= (i == 0) ? din : stage_r[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  assign dout = stage_r[DEPTH-1];
endmodule

// file: tb/adc_power_mode_output_port_tb.sv
// self-checking bench for the converter control and output port
`timescale 1ns/1ns
module adc_power_mode_output_port_tb;
  localparam logic [7:0] CFG = adc_ctrl_pkg::ADDR_CONFIG;
  localparam logic [7:0] PWR = adc_ctrl_pkg::ADDR_POWER;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, REF_EXTERNAL, REF_ON, COARSE_GAIN_ON, CONV_A_ON, CONV_B_ON;
  logic LOW_POWER, DATA_VALID_A, DATA_VALID_B, DATA_DRIVE_LEVEL, CLOCK_DRIVE_LEVEL;
  logic CHAN_A_OE, CHAN_B_OE, SINGLE_ENDED_OUT_CLOCK, DDR_A_OE, DDR_B_OE;
  logic DDR_OUT_CLOCK_POS, DDR_OUT_CLOCK_NEG, se_stb, ddr_stb, spare;
  logic POWER_CODE_PIN_HI = 0, POWER_CODE_PIN_MID = 0, POWER_CODE_PIN_LO = 0;
  logic INTERFACE_SELECT_PIN = 0, SAMPLE_CLOCK = 0, run = 1, ddr = 0;
  logic [13:0] CONV_A_SAMPLE = 14'h0, CONV_B_SAMPLE = 14'h0, CHAN_A_BUS, CHAN_B_BUS;
  logic [3:0] FINE_GAIN_STEPS, f;
  logic [10:0] DDR_A_PAIRS, DDR_B_PAIRS;
  logic [27:0] word, e;
  logic [1:0] mode = 2'h0;
  logic [32:0] rq[$];
  logic [27:0] hist[$], exq[$];
  logic [31:0] rs = 32'h52;
  logic [6:0] ex[8] = '{7'h7F, 7'h3C, 7'h5C, 7'h1C, 7'h00, 7'h0D, 7'h16, 7'h3C};
  logic [6:0] cm[8] = '{7'h7F, 7'h7C, 7'h7C, 7'h7C, 7'h7F, 7'h1F, 7'h1F, 7'h7C};
  int errors = 0, checks = 0, cyc = 0, ph = 0, caps = 0, epoch = 0, seen = 0;

  adc_power_mode_output_port i_adc_power_mode_output_port (.CLK, .RST, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .POWER_CODE_PIN_HI,
    .POWER_CODE_PIN_MID, .POWER_CODE_PIN_LO, .INTERFACE_SELECT_PIN, .SAMPLE_CLOCK,
    .CONV_A_SAMPLE, .CONV_B_SAMPLE, .REF_EXTERNAL, .REF_ON, .COARSE_GAIN_ON,
    .FINE_GAIN_STEPS, .CONV_A_ON, .CONV_B_ON, .LOW_POWER, .DATA_VALID_A, .DATA_VALID_B,
    .DATA_DRIVE_LEVEL, .CLOCK_DRIVE_LEVEL, .CHAN_A_BUS, .CHAN_B_BUS, .CHAN_A_OE,
    .CHAN_B_OE, .SINGLE_ENDED_OUT_CLOCK, .DDR_A_PAIRS, .DDR_B_PAIRS, .DDR_A_OE,
    .DDR_B_OE, .DDR_OUT_CLOCK_POS, .DDR_OUT_CLOCK_NEG);
  adc_rx_model i_adc_rx_model (.clk(CLK), .se_clk(SINGLE_ENDED_OUT_CLOCK),
    .bus_a(CHAN_A_BUS), .bus_b(CHAN_B_BUS), .ddr_clk(DDR_OUT_CLOCK_POS),
    .pairs_a(DDR_A_PAIRS), .pairs_b(DDR_B_PAIRS), .se_stb, .ddr_stb, .word, .spare);

  always #20 CLK = ~CLK;

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [32:0] x, input logic [32:0] g);
    checks++;
    if (g !== x)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // read results are noted here and judged by the bus monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] x);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    if (!w)
      rq.push_back(x);
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
      @(posedge CLK);
    while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic strm(input logic d, input logic [1:0] m, input int n);
    epoch++;
    ddr = d;
    mode = m;
    caps = 0;
    wt(8 * n);
    mode = 2'h0;
    chk("captures", 33'h1, 33'(caps >= n - 18));
    $display("stream test done");
  endtask

  // codes in an order that leaves the slow wake for last
  task automatic pw(input logic pins);
    logic [2:0] c;
    int n;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i < 4 ? i : (i == 7 ? 4 : i + 1));
      if (pins)
        {POWER_CODE_PIN_HI, POWER_CODE_PIN_MID, POWER_CODE_PIN_LO} <= c;
      else
        apb(1'b1, PWR, {29'h0, c}, 33'h0);
      wt(12);
      chk("power", ex[c] & cm[c], {CHAN_A_OE, CHAN_B_OE, CONV_A_ON, CONV_B_ON, REF_ON,
        DATA_VALID_A, DATA_VALID_B} & cm[c]);
    end
    if (pins)
      {POWER_CODE_PIN_HI, POWER_CODE_PIN_MID, POWER_CODE_PIN_LO} <= 3'h0;
    else
      apb(1'b1, PWR, 32'h0, 33'h0);
    n = 0;
    while (DATA_VALID_A !== 1'b1 && n < 600)
    begin
      @(posedge CLK);
      n++;
    end
    chk("wake", 33'h1, 33'(n > 360 && n < 400));
    $display("power test done");
  endtask

  // sampling clock and converter words, expected words noted per rise
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors++;
      summarize();
    end
    if (epoch != seen)
    begin
      hist.delete();
      exq.delete();
      seen = epoch;
    end
    if (run)
    begin
      ph = (ph + 1) % 8;
      if (ph == 0)
      begin
        SAMPLE_CLOCK <= 1'b1;
        // ddr words are assembled at the fall, one rise later than cmos
        if (hist.size() > (ddr ? 15 : 14))
          exq.push_back(hist.pop_front());
      end
      if (ph == 4)
      begin
        SAMPLE_CLOCK <= 1'b0;
        rs = xs(rs);
        CONV_A_SAMPLE <= rs[13:0];
        CONV_B_SAMPLE <= rs[29:16];
        hist.push_back({rs[13:0], rs[29:16]});
      end
    end
  end

  always @(posedge CLK)
  begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && rq.size() > 0)
      chk("read", rq.pop_front(), {PSLVERR, PRDATA});
    if (mode != 0 && (ddr ? ddr_stb : se_stb) === 1'b1 && exq.size() > 0)
    begin
      e = exq.pop_front();
      caps++;
      if (mode == 1)
        chk("data b", 33'(e[13:0]), 33'(word[13:0]));
      else
        chk("data", 33'(e), 33'(word));
      if (ddr)
        chk("ddr spare", 33'h0, 33'(spare));
    end
  end

  initial
  begin
    wt(12);
    RST <= 1'b0;
    wt(1);
    chk("reset", 33'h1C0, {REF_ON, CONV_A_ON, CONV_B_ON, COARSE_GAIN_ON,
      FINE_GAIN_STEPS, CHAN_A_OE});
    apb(1'b0, CFG, 32'h0, 33'h0);
    for (int v = 0; v < 16; v++)
    begin
      f = 4'(v > 12 ? 12 : v);
      apb(1'b1, CFG, {20'h0, 4'h3, 4'(v), 4'h3}, 33'h0);
      wt(2);
      chk("fine", 33'(f), 33'(FINE_GAIN_STEPS));
      chk("cfg", 33'hF, {REF_EXTERNAL, COARSE_GAIN_ON, DATA_DRIVE_LEVEL,
        CLOCK_DRIVE_LEVEL});
      apb(1'b0, CFG, 32'h0, {21'h0, 4'h3, f, 4'h3});
    end
    apb(1'b1, CFG, 32'h0, 33'h0);
    apb(1'b1, 8'h0C, 32'hFFF, 33'h0);
    apb(1'b0, 8'h0C, 32'h0, 33'h1_0000_0000);
    wt(2);
    chk("cfg off", 33'h0, {REF_EXTERNAL, COARSE_GAIN_ON, DATA_DRIVE_LEVEL,
      CLOCK_DRIVE_LEVEL, FINE_GAIN_STEPS});
    $display("config test done");
    strm(1'b0, 2'h2, 40);
    chk("se oe", 33'hC, {CHAN_A_OE, CHAN_B_OE, DDR_A_OE, DDR_B_OE});
    apb(1'b1, CFG, 32'h400, 33'h0);
    strm(1'b1, 2'h2, 40);
    chk("ddr oe", 33'h3, {CHAN_A_OE, CHAN_B_OE, DDR_A_OE, DDR_B_OE});
    chk("ddr clk", 33'(!DDR_OUT_CLOCK_POS), 33'(DDR_OUT_CLOCK_NEG));
    apb(1'b1, CFG, 32'h0, 33'h0);
    pw(1'b0);
    apb(1'b1, PWR, 32'h7, 33'h0);
    strm(1'b0, 2'h1, 40);
    apb(1'b1, PWR, 32'h0, 33'h0);
    apb(1'b1, CFG, 32'h800, 33'h0);
    pw(1'b1);
    INTERFACE_SELECT_PIN <= 1'b1;
    strm(1'b1, 2'h2, 30);
    INTERFACE_SELECT_PIN <= 1'b0;
    apb(1'b0, CFG, 32'h0, 33'h800);
    run = 1'b0;
    wt(40);
    chk("low power", 33'h4, {LOW_POWER, DATA_VALID_A, DATA_VALID_B});
    apb(1'b0, adc_ctrl_pkg::ADDR_STATUS, 32'h0, 33'h90);
    run = 1'b1;
    wt(40);
    chk("low power", 33'h0, 33'(LOW_POWER));
    $display("clock stop test done");
    summarize();
  end
endmodule

// file: tb/adc_rx_model.sv
// receiving logic model that captures the converter output port
`timescale 1ns/1ns
module adc_rx_model (
  input wire logic clk,
  input wire logic se_clk,
  input wire logic [13:0] bus_a,
  input wire logic [13:0] bus_b,
  input wire logic ddr_clk,
  input wire logic [10:0] pairs_a,
  input wire logic [10:0] pairs_b,
  output logic se_stb,
  output logic ddr_stb,
  output logic [27:0] word,
  output logic spare
);
  logic se_q;
  logic ddr_q;
  logic [21:0] odd;
  always @(posedge clk)
  begin
    se_q <= se_clk;
    ddr_q <= ddr_clk;
    se_stb <= se_clk && !se_q;
    ddr_stb <= !ddr_clk && ddr_q;
    if (se_clk && !se_q)
      word <= {bus_a, bus_b};
    if (ddr_clk && !ddr_q)
      odd <= {pairs_a, pairs_b};
    if (!ddr_clk && ddr_q)
    begin
      // odd half from the rise, even half from this fall
      for (int k = 0; k < 7; k++)
      begin
        word[2*k+15] <= odd[k+11];
        word[2*k+14] <= pairs_a[k];
        word[2*k+1] <= odd[k];
        word[2*k] <= pairs_b[k];
      end
      spare <= |{odd[21:18], odd[10:7], pairs_a[10:7], pairs_b[10:7]};
    end
  end
endmodule
